// ===== hdl/fault_wide_pkg.sv
// Constants for the fault trigger conditioning and the 10-bit wide access path.
// Assumes a single 40 MHz system clock and a byte-wide CPU register port.
`default_nettype none
package fault_wide_pkg;
  // ****************************************************
  // Widths and counts
  // ****************************************************
  localparam int WIDE_W        = 10;
  localparam int BYTE_W        = 8;
  localparam int STAGE_W       = 2;
  localparam int FILTER_SAMPLES = 4;
  // ****************************************************
  // Register indices on the CPU port
  // ****************************************************
  localparam logic [2:0] IDX_COUNTER   = 3'h0;
  localparam logic [2:0] IDX_CMP_A     = 3'h1;
  localparam logic [2:0] IDX_CMP_B     = 3'h2;
  localparam logic [2:0] IDX_CMP_C     = 3'h3;
  localparam logic [2:0] IDX_CMP_D     = 3'h4;
  localparam logic [2:0] IDX_STAGING   = 3'h5;
  localparam logic [2:0] IDX_CONTROL_D = 3'h6;
  localparam int         NUM_WIDE      = 5;
  // ****************************************************
  // Control register D fields
  // ****************************************************
  localparam int BIT_FAULT_INT_EN  = 7;
  localparam int BIT_FAULT_PROT_EN = 6;
  localparam int BIT_NOISE_FILT_EN = 5;
  localparam int BIT_EDGE_SEL      = 4;
  localparam int BIT_CMP_SELECT    = 3;
  localparam int BIT_FAULT_FLAG    = 2;
  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0]  RST_CONTROL_D = 8'h00;
  localparam logic [1:0]  RST_STAGING   = 2'h0;
  localparam logic [9:0]  RST_WIDE      = 10'h000;
  localparam logic [7:0]  RST_COMP_MODE = 8'h00;
endpackage
`default_nettype wire

// ===== hdl/fault_trigger_cond.sv
// Fault trigger conditioning: synchroniser, optional four-sample filter, edge detector.
// Assumes inputs are asynchronous pins; select bits come from the same clock domain.
`default_nettype none
module fault_trigger_cond #(
  parameter int SAMPLES = fault_wide_pkg::FILTER_SAMPLES
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic pin_in,
  input  wire logic cmp_in,
  input  wire logic cmp_select,
  input  wire logic filter_en,
  input  wire logic edge_rising,
  output logic      edge_seen
);
  logic [1:0]         pin_sync_r;
  logic [1:0]         cmp_sync_r;
  logic               src;
  logic [SAMPLES-2:0] hist_r;
  logic [SAMPLES-1:0] window;
  logic               filt_r;
  logic               level;
  logic               prev_r;

  // ****************************************************
  // Synchronisers, same sampling for both sources
  // ****************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pin_sync_r <= 2'h0;
      cmp_sync_r <= 2'h0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[0], pin_in};
      cmp_sync_r <= {cmp_sync_r[0], cmp_in};
    end
  end

  assign src = cmp_select ? cmp_sync_r[1] : pin_sync_r[1];

  // ****************************************************
  // Noise filter, sampled on every system clock
  // ****************************************************
  // Window is three stored samples plus the current one, so the filtered
  // path lags the bypass path by exactly four clocks, not five
  assign window = {hist_r, src};

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      hist_r <= '0;
      filt_r <= 1'b0;
    end
    else
    begin
      hist_r <= window[SAMPLES-2:0];
      if (&window || ~|window)
        filt_r <= src;
    end
  end

  assign level = filter_en ? filt_r : src;

  // ****************************************************
  // Edge detector
  // ****************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      prev_r    <= 1'b0;
      edge_seen <= 1'b0;
    end
    else
    begin
      prev_r    <= level;
      edge_seen <= edge_rising ? (level & ~prev_r) : (~level & prev_r);
    end
  end

  a_filter_needs_agree : assert property (@(posedge clock) disable iff (reset)
    (filter_en && $changed(filt_r)) |-> $past(&window) || $past(~|window))
    else $error("filter output changed without agreeing samples");
endmodule
`default_nettype wire

// ===== hdl/fault_wide_top.sv
// Fault protection trigger and 10-bit wide register access for a PWM timer.
// Assumes a byte-wide CPU port with one-cycle read and write strobes, single clock.
// Function
// - The fault trigger comes from the fault pin, or from the comparator when the select bit is set.
// - Both sources are synchronised and edge-detected with the counter input pin's logic.
// - The enabled filter sits ahead of the edge detector and adds four clocks of latency.
// - The filter output changes only after four equal consecutive samples.
// - The filter enable bit in control D turns the filter on; otherwise it is bypassed.
// - The filter samples every system clock regardless of prescaler.
// - Software can cause a fault by driving the fault pin's port output.
// - Counter and compare values are 10 bits, reached as bytes with one shared 2-bit staging register.
// - Only a low-byte access moves data; staging accesses leave wide registers alone.
// - A low-byte write loads staging bits and data byte together in one clock.
// - A low-byte read copies the upper bits into staging in the same clock.
// - A qualifying edge with protection enabled clears output modes and the enable together.
// - A fault raises the interrupt if enabled; otherwise software polls the enable bit.
`default_nettype none
module fault_wide_top (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  output logic      [7:0] rd_data,
  input  wire logic       external_fault_pin,
  input  wire logic       comparator_output,
  input  wire logic [7:0] compare_output_mode_set,
  input  wire logic       compare_output_mode_load,
  output logic      [7:0] compare_output_mode,
  output logic            fault_irq,
  output logic [9:0]      counter_value,
  output logic [9:0]      compare_a,
  output logic [9:0]      compare_b,
  output logic [9:0]      compare_c,
  output logic [9:0]      compare_d
);
  logic [1:0] high_bits_staging_r;
  logic [7:0] timer_control_d_r;
  logic [9:0] wide_r [fault_wide_pkg::NUM_WIDE];
  logic       edge_seen;
  logic       fault_evt;

  function automatic logic is_wide(input logic [2:0] a);
    is_wide = (a <= fault_wide_pkg::IDX_CMP_D);
  endfunction

  // ****************************************************
  // Fault trigger conditioning
  // ****************************************************
  fault_trigger_cond #(
    .SAMPLES (fault_wide_pkg::FILTER_SAMPLES)
  ) u_cond (
    .clock       (clock),
    .reset       (reset),
    .pin_in      (external_fault_pin),
    .cmp_in      (comparator_output),
    .cmp_select  (timer_control_d_r[fault_wide_pkg::BIT_CMP_SELECT]),
    .filter_en   (timer_control_d_r[fault_wide_pkg::BIT_NOISE_FILT_EN]),
    .edge_rising (timer_control_d_r[fault_wide_pkg::BIT_EDGE_SEL]),
    .edge_seen   (edge_seen)
  );

  assign fault_evt = edge_seen & timer_control_d_r[fault_wide_pkg::BIT_FAULT_PROT_EN];

  // ****************************************************
  // Control register D; fault flag set wins over a clear
  // ****************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      timer_control_d_r <= fault_wide_pkg::RST_CONTROL_D;
    else
    begin
      if (wr_strobe && reg_addr == fault_wide_pkg::IDX_CONTROL_D)
      begin
        timer_control_d_r <= wr_data;
        // Flag is write-one-to-clear so a plain config write keeps it
        timer_control_d_r[fault_wide_pkg::BIT_FAULT_FLAG] <=
          timer_control_d_r[fault_wide_pkg::BIT_FAULT_FLAG] &
          ~wr_data[fault_wide_pkg::BIT_FAULT_FLAG];
      end
      if (edge_seen)
        timer_control_d_r[fault_wide_pkg::BIT_FAULT_FLAG] <= 1'b1;
      if (fault_evt)
        timer_control_d_r[fault_wide_pkg::BIT_FAULT_PROT_EN] <= 1'b0;
    end
  end

  // ****************************************************
  // Compare output modes, forced to port control by a fault
  // ****************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      compare_output_mode <= fault_wide_pkg::RST_COMP_MODE;
    else if (fault_evt)
      compare_output_mode <= fault_wide_pkg::RST_COMP_MODE;
    else if (compare_output_mode_load)
      compare_output_mode <= compare_output_mode_set;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      fault_irq <= 1'b0;
    else
      fault_irq <= timer_control_d_r[fault_wide_pkg::BIT_FAULT_FLAG] &
                   timer_control_d_r[fault_wide_pkg::BIT_FAULT_INT_EN];
  end

  // ****************************************************
  // Wide registers and the shared staging register
  // ****************************************************
  // Staging is shared, so an interrupt between two byte accesses corrupts the pair
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      high_bits_staging_r <= fault_wide_pkg::RST_STAGING;
    else if (wr_strobe && reg_addr == fault_wide_pkg::IDX_STAGING)
      high_bits_staging_r <= wr_data[1:0];
    else if (rd_strobe && is_wide(reg_addr))
      high_bits_staging_r <= wide_r[reg_addr][9:8];
  end

  genvar g;
  generate
    for (g = 0; g < fault_wide_pkg::NUM_WIDE; g++)
    begin : g_wide
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
          wide_r[g] <= fault_wide_pkg::RST_WIDE;
        else if (wr_strobe && reg_addr == 3'(g))
          wide_r[g] <= {high_bits_staging_r, wr_data};
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rd_data <= 8'h00;
    else if (rd_strobe)
    begin
      if (is_wide(reg_addr))
        rd_data <= wide_r[reg_addr][7:0];
      else if (reg_addr == fault_wide_pkg::IDX_STAGING)
        rd_data <= {6'h00, high_bits_staging_r};
      else if (reg_addr == fault_wide_pkg::IDX_CONTROL_D)
        rd_data <= timer_control_d_r;
      else
        rd_data <= 8'h00;
    end
  end

  assign counter_value = wide_r[0];
  assign compare_a     = wide_r[1];
  assign compare_b     = wide_r[2];
  assign compare_c     = wide_r[3];
  assign compare_d     = wide_r[4];

  // ****************************************************
  // Checks
  // ****************************************************
  // Properties sample on the edge that launches the registers they watch,
  // so a one-cycle strobe is checked against the state it leaves behind
  sequence s_low_write;
    wr_strobe && is_wide(reg_addr);
  endsequence

  sequence s_wide_read;
    rd_strobe && is_wide(reg_addr);
  endsequence

  sequence s_staging_read;
    rd_strobe && reg_addr == fault_wide_pkg::IDX_STAGING;
  endsequence

  sequence s_irq_raise;
    timer_control_d_r[fault_wide_pkg::BIT_FAULT_FLAG] ##1 fault_irq;
  endsequence

  a_wide_write_load : assert property (@(posedge clock) disable iff (reset)
    s_low_write |=> wide_r[$past(reg_addr)] == {$past(high_bits_staging_r), $past(wr_data)})
    else $error("wide write did not merge staging and low byte");
  a_wide_read_copy : assert property (@(posedge clock) disable iff (reset)
    s_wide_read |=> high_bits_staging_r == $past(wide_r[reg_addr][9:8]))
    else $error("wide read did not copy upper bits to staging");
  a_wide_read_low : assert property (@(posedge clock) disable iff (reset)
    s_wide_read |=> rd_data == $past(wide_r[reg_addr][7:0]))
    else $error("wide read returned the wrong low byte");
  a_staging_write_load : assert property (@(posedge clock) disable iff (reset)
    (wr_strobe && reg_addr == fault_wide_pkg::IDX_STAGING) |=>
      high_bits_staging_r == $past(wr_data[1:0]))
    else $error("staging write did not take the low two bits");
  a_staging_no_load : assert property (@(posedge clock) disable iff (reset)
    (wr_strobe && reg_addr == fault_wide_pkg::IDX_STAGING) |=>
      $stable({counter_value, compare_a, compare_b, compare_c, compare_d}))
    else $error("staging write changed a wide register");
  a_staging_read_back : assert property (@(posedge clock) disable iff (reset)
    s_staging_read |=> rd_data == {6'h00, $past(high_bits_staging_r)})
    else $error("staging read returned the wrong bits");
  a_read_data_hold : assert property (@(posedge clock) disable iff (reset)
    !rd_strobe |=> $stable(rd_data))
    else $error("read data changed without a read");
  a_fault_clears_en : assert property (@(posedge clock) disable iff (reset)
    fault_evt |=> !timer_control_d_r[fault_wide_pkg::BIT_FAULT_PROT_EN]
                  && compare_output_mode == fault_wide_pkg::RST_COMP_MODE)
    else $error("fault did not clear enable and output modes");
  a_modes_hold : assert property (@(posedge clock) disable iff (reset)
    (!fault_evt && !compare_output_mode_load) |=> $stable(compare_output_mode))
    else $error("output modes changed without a load or a fault");
  a_flag_on_edge : assert property (@(posedge clock) disable iff (reset)
    edge_seen |=> timer_control_d_r[fault_wide_pkg::BIT_FAULT_FLAG])
    else $error("qualifying edge did not set the fault flag");
  a_fault_irq_out : assert property (@(posedge clock) disable iff (reset)
    (fault_evt && timer_control_d_r[fault_wide_pkg::BIT_FAULT_INT_EN]) |=> s_irq_raise)
    else $error("fault interrupt not raised");
  a_irq_quiet : assert property (@(posedge clock) disable iff (reset)
    !timer_control_d_r[fault_wide_pkg::BIT_FAULT_INT_EN] |=> !fault_irq)
    else $error("fault interrupt raised while disabled");
endmodule
`default_nettype wire

// ===== verification/cpu_bus_model.sv
// CPU side model: byte register reads and writes, and wide pairs.
// Assumes one-cycle strobes and read data one edge after the read strobe.
`default_nettype none
module cpu_bus_model (
  input  wire logic       clock,
  output logic      [2:0] reg_addr,
  output logic      [7:0] wr_data,
  output logic            wr_strobe,
  output logic            rd_strobe,
  input  wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_addr  = 3'h0;
    wr_data   = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end
  // ****
  // Byte and wide accesses
  // ****
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    wr_data   = d;
    wr_strobe = 1'b1;
    @(posedge clock);
    #1;
    wr_strobe = 1'b0;
    wr_data   = ~d;  // Stale data must not look valid
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    rd_strobe = 1'b1;
    @(posedge clock);
    #1;
    rd_strobe = 1'b0;
    d         = rd_data;
  endtask
  // Calls never interleave, so no pair is split
  task automatic wide_wr(input logic [2:0] a, input logic [9:0] v);
    wr(fault_wide_pkg::IDX_STAGING, {6'h00, v[9:8]});
    wr(a, v[7:0]);
  endtask
  task automatic wide_rd(input logic [2:0] a, output logic [9:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(fault_wide_pkg::IDX_STAGING, hi);
    v = {hi[1:0], lo};
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_fault_wide_top.sv
// Bench for the fault trigger and wide register block.
// Assumes all register traffic goes through the CPU model.
`default_nettype none
module tb_fault_wide_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] STG = fault_wide_pkg::IDX_STAGING;
  localparam logic [2:0] CTL = fault_wide_pkg::IDX_CONTROL_D;
  logic                 clock;
  logic                 reset;
  logic           [2:0] reg_addr;
  logic           [7:0] wr_data;
  logic                 wr_strobe;
  logic                 rd_strobe;
  logic           [7:0] rd_data;
  logic                 pin;
  logic                 cmp;
  logic           [7:0] mode_set;
  logic                 mode_load;
  logic           [7:0] mode;
  logic                 irq;
  wire logic [4:0][9:0] wide_q;
  logic           [9:0] v;
  logic           [7:0] b;
  int                   n_raw;
  int                   n_filt;
  int                   cycles = 0;
  int                   miscompares = 0;
  int                   checked = 0;
  fault_wide_top dut (
    .clock(clock),
    .reset(reset),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data),
    .external_fault_pin(pin),
    .comparator_output(cmp),
    .compare_output_mode_set(mode_set),
    .compare_output_mode_load(mode_load),
    .compare_output_mode(mode),
    .fault_irq(irq),
    .counter_value(wide_q[0]),
    .compare_a(wide_q[1]),
    .compare_b(wide_q[2]),
    .compare_c(wide_q[3]),
    .compare_d(wide_q[4])
  );
  cpu_bus_model cpu (
    .clock(clock),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data)
  );
  // ****
  // Helpers
  // ****
  function automatic logic [9:0] pat(input int i);
    return 10'h3c3 - 10'(i * 199);
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Settle the new source and edge first, then enable and clear the flag
  task automatic arm(input logic [7:0] extra);
    cpu.wr(CTL, extra);
    step(10);
    cpu.wr(CTL, extra | 8'h44);
    mode_set  = 8'hff;
    mode_load = 1'b1;
    step(1);
    mode_load = 1'b0;
  endtask
  task automatic wait_clear(output int n);
    n = 0;
    while (mode !== 8'h00 && n < 20)
    begin
      step(1);
      n++;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    reset     = 1'b1;
    pin       = 1'b0;
    cmp       = 1'b0;
    mode_set  = 8'h00;
    mode_load = 1'b0;
    step(6);
    reset = 1'b0;
    cpu.rd(CTL, b);
    check(b, fault_wide_pkg::RST_CONTROL_D);
    cpu.rd(STG, b);
    check(b, fault_wide_pkg::RST_STAGING);
    for (int i = 0; i < fault_wide_pkg::NUM_WIDE; i++)
    begin
      cpu.wide_wr(3'(i), pat(i));
      check(wide_q[i], pat(i));
    end
    for (int i = 0; i < fault_wide_pkg::NUM_WIDE; i++)
    begin
      cpu.wide_rd(3'(i), v);
      check(v, pat(i));
    end
    cpu.wr(STG, 8'h01);
    cpu.wr(3'h7, 8'hff);
    check(wide_q[0], pat(0));
    cpu.rd(3'h7, b);
    check(b, 8'h00);
    cpu.rd(STG, b);
    check(b, 8'h01);
    arm(8'h10);
    pin = 1'b1;
    wait_clear(n_raw);
    check(mode, 8'h00);
    cpu.rd(CTL, b);
    check(b[6], 1'b0);
    check(b[2], 1'b1);
    check(irq, 1'b0);
    pin = 1'b0;
    arm(8'hb0);
    pin = 1'b1;
    wait_clear(n_filt);
    check(10'(n_filt - n_raw), 10'h004);
    step(2);
    check(irq, 1'b1);
    pin = 1'b0;
    arm(8'h30);
    pin = 1'b1;
    step(3);
    pin = 1'b0;
    step(15);
    check(mode, 8'hff);
    arm(8'h18);
    pin = 1'b1;
    step(15);
    check(mode, 8'hff);
    cmp = 1'b1;
    wait_clear(n_raw);
    check(mode, 8'h00);
    arm(8'h00);
    pin = 1'b0;
    wait_clear(n_raw);
    check(mode, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
